// >>> logic/tla_pkg.sv
// Shared constants, types and helpers of the temperature limit and alert logic
package tla_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned NS_PER_US      = 1000;
    localparam int unsigned CYC_PER_US     = NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned CONV_TIME_US   = 7800;      // Typical conversion time, 7.8 ms
    localparam int unsigned RATE0_PERIOD_US = 4000000;  // 0.25 Hz
    localparam int unsigned RATE1_PERIOD_US = 1000000;  // 1 Hz
    localparam int unsigned RATE2_PERIOD_US = 250000;   // 4 Hz
    localparam int unsigned RATE3_PERIOD_US = 62500;    // 16 Hz
    localparam int unsigned CONV_CYCLES_DEF  = CONV_TIME_US * CYC_PER_US;
    localparam int unsigned RATE0_CYCLES_DEF = RATE0_PERIOD_US * CYC_PER_US;
    localparam int unsigned RATE1_CYCLES_DEF = RATE1_PERIOD_US * CYC_PER_US;
    localparam int unsigned RATE2_CYCLES_DEF = RATE2_PERIOD_US * CYC_PER_US;
    localparam int unsigned RATE3_CYCLES_DEF = RATE3_PERIOD_US * CYC_PER_US;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer codes
    localparam logic [1:0] PTR_RESULT = 2'h0;
    localparam logic [1:0] PTR_CONFIG = 2'h1;
    localparam logic [1:0] PTR_LOWER  = 2'h2;
    localparam logic [1:0] PTR_UPPER  = 2'h3;

    // Configuration word layout
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_TM_BIT    = 2;
    localparam int CFG_UNDER_BIT = 3;
    localparam int CFG_OVER_BIT  = 4;
    localparam int CFG_RATE_LSB  = 5;
    localparam int CFG_HYS_LSB   = 12;
    localparam int CFG_POL_BIT   = 15;

    // Modes, rates, hysteresis codes
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_ONESHOT  = 2'h1;
    localparam logic [1:0] MODE_CONT     = 2'h2;
    localparam int         MODE_CONT_BIT = 1;
    localparam logic [1:0] RATE_RST      = 2'h1;
    localparam logic [1:0] HYS_RST       = 2'h1;
    localparam logic [1:0] HYS_SEL_0C    = 2'h0;
    localparam logic [1:0] HYS_SEL_1C    = 2'h1;
    localparam logic [1:0] HYS_SEL_2C    = 2'h2;
    localparam int unsigned HYS_COUNTS_PER_C = 16;      // 1 degree at 0.0625 per count
    localparam int unsigned HYS_DEG_1C   = 1;
    localparam int unsigned HYS_DEG_2C   = 2;
    localparam int unsigned HYS_DEG_4C   = 4;

    // Result and limit word layout, reset values
    localparam int          RES_MSB         = 15;
    localparam int          RES_LSB         = 4;
    localparam logic [3:0]  LOW_NIBBLE_ZERO = 4'h0;
    localparam logic [15:0] LIMIT_MASK      = 16'hFFF0;
    localparam logic [15:0] RESULT_RST      = 16'h0000;
    localparam logic [15:0] UPPER_RST       = 16'h7FF8;
    localparam logic [15:0] LOWER_RST       = 16'hB500;
    localparam logic [15:0] RDATA_RST       = 16'h0000;
    localparam logic        ALERT_PIN_RST   = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic       alert_sense_invert;
        logic [1:0] hysteresis_select;
        logic [1:0] sample_rate_select;
        logic       thermostat_select;
        logic [1:0] op_mode_select;
    } tla_cfg_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [1:0]  ptr;
        logic [15:0] wdata;
    } tla_req_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONV,
        SEQ_WAIT
    } tla_seq_state_t;

    localparam tla_cfg_t CFG_RST = '{alert_sense_invert: 1'b0, hysteresis_select: HYS_RST,
                                     sample_rate_select: RATE_RST, thermostat_select: 1'b0,
                                     op_mode_select: MODE_CONT};

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [11:0] tla_get_t12(input logic [15:0] w);
        return w[RES_MSB:RES_LSB];
    endfunction : tla_get_t12

    function automatic logic [15:0] tla_put_t12(input logic [11:0] t);
        return {t, LOW_NIBBLE_ZERO};
    endfunction : tla_put_t12

    function automatic logic signed [12:0] tla_hys_counts(input logic [1:0] sel);
        case (sel)
            HYS_SEL_0C: return 13'sh0;
            HYS_SEL_1C: return 13'(HYS_DEG_1C * HYS_COUNTS_PER_C);
            HYS_SEL_2C: return 13'(HYS_DEG_2C * HYS_COUNTS_PER_C);
            default:    return 13'(HYS_DEG_4C * HYS_COUNTS_PER_C);
        endcase
    endfunction : tla_hys_counts

    function automatic logic [15:0] tla_pack_cfg(input tla_cfg_t c, input logic over, input logic under);
        logic [15:0] w;
        w = 16'h0000;
        w[CFG_MODE_LSB +: 2] = c.op_mode_select;
        w[CFG_TM_BIT]        = c.thermostat_select;
        w[CFG_UNDER_BIT]     = under;
        w[CFG_OVER_BIT]      = over;
        w[CFG_RATE_LSB +: 2] = c.sample_rate_select;
        w[CFG_HYS_LSB +: 2]  = c.hysteresis_select;
        w[CFG_POL_BIT]       = c.alert_sense_invert;
        return w;
    endfunction : tla_pack_cfg

endpackage : tla_pkg

// >>> logic/tla_cmp.sv
// Signed limit comparison of a fresh result against both thresholds
`timescale 1ns/1ns
module tla_cmp
    import tla_pkg::*;
(
    input  wire logic [11:0] temp_t12,
    input  wire logic [11:0] upper_t12,
    input  wire logic [11:0] lower_t12,
    input  wire logic [1:0]  hys_sel,
    output logic             over_hit,
    output logic             under_hit,
    output logic             in_release
);
    // One extra bit keeps lower+hys and upper-hys from wrapping at the range ends
    logic signed [12:0] t_s;
    logic signed [12:0] hi_s;
    logic signed [12:0] lo_s;
    logic signed [12:0] hys_s;

    always_comb begin
        t_s        = signed'({temp_t12[11], temp_t12});
        hi_s       = signed'({upper_t12[11], upper_t12});
        lo_s       = signed'({lower_t12[11], lower_t12});
        hys_s      = tla_hys_counts(hys_sel);                        // see R1, R27
        over_hit   = t_s > hi_s;                                     // see R4
        under_hit  = t_s < lo_s;                                     // see R5
        in_release = (t_s >= 13'(lo_s + hys_s)) && (t_s <= 13'(hi_s - hys_s)); // see R18
    end

endmodule : tla_cmp

// >>> logic/tla_seq.sv
// Conversion sequencer: timed conversions, standby interval and one-shot runs
`timescale 1ns/1ns
module tla_seq
    import tla_pkg::*;
#(
    parameter int unsigned CONV_CYCLES  = CONV_CYCLES_DEF,
    parameter int unsigned RATE0_CYCLES = RATE0_CYCLES_DEF,
    parameter int unsigned RATE1_CYCLES = RATE1_CYCLES_DEF,
    parameter int unsigned RATE2_CYCLES = RATE2_CYCLES_DEF,
    parameter int unsigned RATE3_CYCLES = RATE3_CYCLES_DEF
)(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       restart,
    input  wire logic [1:0] mode,
    input  wire logic [1:0] rate,
    output logic            conv_busy,
    output logic            conv_done
);
    tla_seq_state_t state_reg, state_next;
    logic [31:0]    cnt_reg, cnt_next;
    logic           done_reg, done_next;
    logic [31:0]    period;

    // Period measured from the start of one conversion to the start of the next
    always_comb begin
        case (rate)
            2'h0:    period = RATE0_CYCLES;
            2'h1:    period = RATE1_CYCLES;
            2'h2:    period = RATE2_CYCLES;
            default: period = RATE3_CYCLES;
        endcase                                                       // see R9
    end

    // Next state; a conversion runs to its end unless restart starts it over, so mode writes only act between
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 32'h1;
        done_next  = 1'b0;
        case (state_reg)
            SEQ_IDLE: begin
                cnt_next = 32'h0;
                // done_reg blocks a restart while the one-shot mode bits are being cleared
                if (mode[MODE_CONT_BIT] || (mode == MODE_ONESHOT && !done_reg)) begin
                    state_next = SEQ_CONV;                            // see R23
                end
            end
            SEQ_CONV: begin
                if (cnt_reg == CONV_CYCLES - 1) begin
                    done_next  = 1'b1;
                    state_next = mode[MODE_CONT_BIT] ? SEQ_WAIT : SEQ_IDLE; // see R22
                end
            end
            SEQ_WAIT: begin
                if (!mode[MODE_CONT_BIT]) begin
                    state_next = SEQ_IDLE;
                end else if (cnt_reg >= period - 1) begin
                    state_next = SEQ_CONV;                            // see R24
                    cnt_next   = 32'h0;
                end
            end
            default: state_next = SEQ_IDLE;
        endcase
        if (restart) begin
            state_next = SEQ_CONV;                                    // see R10
            cnt_next   = 32'h0;
            done_next  = 1'b0;
        end
    end

    // Reset lands in a conversion so the first result follows power-up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SEQ_CONV;                                    // see R10
            cnt_reg   <= 32'h0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            done_reg  <= done_next;
        end
    end

    assign conv_busy = (state_reg == SEQ_CONV);
    assign conv_done = done_reg;

    // A conversion ends exactly after its full count
    conv_length_a: assert property (@(posedge clk) disable iff (!nrst) // see R10
        (state_reg == SEQ_CONV && cnt_reg == CONV_CYCLES - 1 && !restart) |=> conv_done)
        else $error("conversion did not end at its count");

endmodule : tla_seq

// >>> logic/tla_core.sv
// Result, limit, configuration and alert logic of the temperature sensor
// What this block does
// R1 - Hysteresis select: 0, 1, 2, 4 degrees
// R2 - Thermostat bit: 1 interrupt, 0 comparator
// R3 - Alert pin polarity from sense invert bit
// R4 - Over flag when result above upper
// R5 - Under flag when result below lower
// R6 - Comparator mode: inside window both flags read zero
// R7 - Interrupt mode: alert response releases pin, keeps flags
// R8 - Interrupt mode: config read clears flags and pin
// R9 - Rate field sets continuous conversion rate
// R10 - Convert after reset or general call
// R11 - Result register updated every conversion
// R12 - Result twelve bits, left justified
// R13 - Controller reads both result bytes
// R14 - Interrupt mode: alert on limit crossing
// R15 - Interrupt mode: alert response releases the alert
// R16 - General call reset releases alert
// R17 - Comparator mode: alert outside limits
// R18 - Comparator release inside hysteresis window
// R19 - Limits reset to wide open window
// R20 - Limits coded like the result
// R21 - Shutdown, one-shot and continuous modes
// R22 - Shutdown finishes running conversion first
// R23 - One-shot runs once, mode returns 00
// R24 - Continuous: convert, wait, repeat
// R25 - Configuration word bit layout
// R26 - Two-bit pointer selects register
// R27 - Hysteresis counted as sixteen per degree
`timescale 1ns/1ns
module tla_core
    import tla_pkg::*;
#(
    parameter int unsigned CONV_CYCLES  = CONV_CYCLES_DEF,
    parameter int unsigned RATE0_CYCLES = RATE0_CYCLES_DEF,
    parameter int unsigned RATE1_CYCLES = RATE1_CYCLES_DEF,
    parameter int unsigned RATE2_CYCLES = RATE2_CYCLES_DEF,
    parameter int unsigned RATE3_CYCLES = RATE3_CYCLES_DEF
)(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire tla_req_t    req,
    output logic [15:0]      rdata,
    input  wire logic        ara_ok,
    input  wire logic        gc_reset,
    input  wire logic [11:0] adc_value,
    output logic             conv_active,
    output logic             alert_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    tla_cfg_t    cfg_reg, cfg_next;
    logic        over_reg, over_next;
    logic        under_reg, under_next;
    logic        active_reg, active_next;
    logic        alert_out_reg, alert_out_next;
    logic [15:0] result_reg, result_next;
    logic [15:0] upper_reg, upper_next;
    logic [15:0] lower_reg, lower_next;
    logic [15:0] rdata_reg, rdata_next;

    logic conv_done;
    logic over_hit;
    logic under_hit;
    logic in_release;
    logic wr_cfg;
    logic rd_cfg;
    logic int_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and comparator
    tla_seq #(
        .CONV_CYCLES  (CONV_CYCLES),
        .RATE0_CYCLES (RATE0_CYCLES),
        .RATE1_CYCLES (RATE1_CYCLES),
        .RATE2_CYCLES (RATE2_CYCLES),
        .RATE3_CYCLES (RATE3_CYCLES)
    ) u_seq (
        .clk       (clk),
        .nrst      (nrst),
        .restart   (gc_reset),
        .mode      (cfg_reg.op_mode_select),
        .rate      (cfg_reg.sample_rate_select),
        .conv_busy (conv_active),
        .conv_done (conv_done)
    );

    // Compare the fresh sample, not the stored one, so flags match the new result
    tla_cmp u_cmp (
        .temp_t12   (adc_value),
        .upper_t12  (tla_get_t12(upper_reg)),
        .lower_t12  (tla_get_t12(lower_reg)),
        .hys_sel    (cfg_reg.hysteresis_select),
        .over_hit   (over_hit),
        .under_hit  (under_hit),
        .in_release (in_release)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    assign wr_cfg   = req.wr && (req.ptr == PTR_CONFIG);              // see R26
    assign rd_cfg   = req.rd && (req.ptr == PTR_CONFIG);
    assign int_mode = cfg_reg.thermostat_select;                      // see R2

    ////////////////////////////////////////////////////////////////////////////
    // Registers, flags and alert: next values
    always_comb begin
        cfg_next    = cfg_reg;
        over_next   = over_reg;
        under_next  = under_reg;
        active_next = active_reg;
        result_next = result_reg;
        upper_next  = upper_reg;
        lower_next  = lower_reg;
        rdata_next  = rdata_reg;

        // New measurement replaces the read-only result
        if (conv_done) begin
            result_next = tla_put_t12(adc_value);                     // see R11, R12
        end

        // Configuration write; flags are hardware owned and ignore written bits
        if (wr_cfg) begin
            cfg_next.op_mode_select     = req.wdata[CFG_MODE_LSB +: 2]; // see R21, R25
            cfg_next.thermostat_select  = req.wdata[CFG_TM_BIT];
            cfg_next.sample_rate_select = req.wdata[CFG_RATE_LSB +: 2];
            cfg_next.hysteresis_select  = req.wdata[CFG_HYS_LSB +: 2];
            cfg_next.alert_sense_invert = req.wdata[CFG_POL_BIT];
        end else if (conv_done && cfg_reg.op_mode_select == MODE_ONESHOT) begin
            cfg_next.op_mode_select = MODE_SHUTDOWN;                  // see R23
        end

        // Limit writes drop the low nibble so limits stay in result format
        if (req.wr && req.ptr == PTR_UPPER) begin
            upper_next = req.wdata & LIMIT_MASK;                      // see R20
        end
        if (req.wr && req.ptr == PTR_LOWER) begin
            lower_next = req.wdata & LIMIT_MASK;                      // see R20
        end

        if (int_mode) begin
            // Interrupt mode: sticky flags; a new event outranks a same-cycle clear
            if (rd_cfg) begin
                over_next   = 1'b0;                                   // see R8
                under_next  = 1'b0;
                active_next = 1'b0;
            end
            if (ara_ok) begin
                active_next = 1'b0;                                   // see R7, R15
            end
            if (conv_done) begin
                over_next   = over_next | over_hit;                   // see R4
                under_next  = under_next | under_hit;                 // see R5
                if (over_hit || under_hit) begin
                    active_next = 1'b1;                               // see R14
                end
            end
        end else if (conv_done) begin
            // Comparator mode: flags track the latest result, alert holds in the band
            over_next  = over_hit;                                    // see R4, R6
            under_next = under_hit;                                   // see R5, R6
            if (over_hit || under_hit) begin
                active_next = 1'b1;                                   // see R17
            end else if (in_release) begin
                active_next = 1'b0;                                   // see R18
            end
        end

        // Read data is captured before any read side effect lands
        if (req.rd) begin
            case (req.ptr)
                PTR_RESULT: rdata_next = result_reg;                  // see R26
                PTR_CONFIG: rdata_next = tla_pack_cfg(cfg_reg, over_reg, under_reg);
                PTR_LOWER:  rdata_next = lower_reg;
                default:    rdata_next = upper_reg;
            endcase
        end

        // General call reset returns configuration, flags, alert and limits to reset values and outranks their other updates; the result is kept
        if (gc_reset) begin
            cfg_next    = CFG_RST;
            over_next   = 1'b0;
            under_next  = 1'b0;
            active_next = 1'b0;                                       // see R16
            upper_next  = UPPER_RST;                                  // see R19
            lower_next  = LOWER_RST;
        end

        // Pin level from the next state keeps pin and state in step
        alert_out_next = cfg_next.alert_sense_invert ? active_next : !active_next; // see R3
    end

    // Registers only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg       <= CFG_RST;
            over_reg      <= 1'b0;
            under_reg     <= 1'b0;
            active_reg    <= 1'b0;
            alert_out_reg <= ALERT_PIN_RST;
            result_reg    <= RESULT_RST;
            upper_reg     <= UPPER_RST;                               // see R19
            lower_reg     <= LOWER_RST;
            rdata_reg     <= RDATA_RST;
        end else begin
            cfg_reg       <= cfg_next;
            over_reg      <= over_next;
            under_reg     <= under_next;
            active_reg    <= active_next;
            alert_out_reg <= alert_out_next;
            result_reg    <= result_next;
            upper_reg     <= upper_next;
            lower_reg     <= lower_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign rdata     = rdata_reg;
    assign alert_out = alert_out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_int_event;
        int_mode && conv_done && (over_hit || under_hit) && !gc_reset;
    endsequence

    sequence s_comp_band;
        !int_mode && conv_done && !over_hit && !under_hit && !in_release && !gc_reset;
    endsequence

    sequence s_ara_only;
        int_mode && ara_ok && !conv_done && !gc_reset && !rd_cfg && !wr_cfg;
    endsequence

    over_flag_a: assert property (@(posedge clk) disable iff (!nrst) // see R4
        (conv_done && over_hit && !gc_reset) |=> over_reg)
        else $error("over flag missed");

    under_flag_a: assert property (@(posedge clk) disable iff (!nrst) // see R5
        (conv_done && under_hit && !gc_reset) |=> under_reg)
        else $error("under flag missed");

    window_flags_a: assert property (@(posedge clk) disable iff (!nrst) // see R6
        (!int_mode && conv_done && !over_hit && !under_hit) |=> (!over_reg && !under_reg))
        else $error("flags set inside window");

    ara_release_a: assert property (@(posedge clk) disable iff (!nrst) // see R7
        s_ara_only |=> (!active_reg && over_reg == $past(over_reg) && under_reg == $past(under_reg)))
        else $error("alert response mishandled");

    cfg_read_clear_a: assert property (@(posedge clk) disable iff (!nrst) // see R8
        (int_mode && rd_cfg && !conv_done && !gc_reset) |=> (!over_reg && !under_reg && !active_reg))
        else $error("config read did not clear");

    int_alert_set_a: assert property (@(posedge clk) disable iff (!nrst) // see R14
        s_int_event |=> (active_reg ##1 (active_reg || $past(ara_ok) || $past(rd_cfg) || $past(gc_reset))))
        else $error("interrupt alert not raised");

    comp_hold_a: assert property (@(posedge clk) disable iff (!nrst) // see R18
        s_comp_band |=> (active_reg == $past(active_reg)))
        else $error("comparator alert moved inside band");

    pin_sense_a: assert property (@(posedge clk) disable iff (!nrst) // see R3
        alert_out == (cfg_reg.alert_sense_invert ? active_reg : !active_reg))
        else $error("alert pin level wrong");

    result_load_a: assert property (@(posedge clk) disable iff (!nrst) // see R11
        conv_done |=> (rdata_reg == $past(rdata_next) && result_reg == tla_put_t12($past(adc_value))))
        else $error("result not loaded");

    gc_release_a: assert property (@(posedge clk) disable iff (!nrst) // see R16
        gc_reset |=> (!active_reg && upper_reg == UPPER_RST && lower_reg == LOWER_RST && cfg_reg == CFG_RST))
        else $error("general call reset incomplete");

    // A write in the cycle after the clear may legally change the mode again
    oneshot_end_a: assert property (@(posedge clk) disable iff (!nrst) // see R23
        (conv_done && cfg_reg.op_mode_select == MODE_ONESHOT && !wr_cfg && !gc_reset)
        |=> (cfg_reg.op_mode_select == MODE_SHUTDOWN)
        ##1 (cfg_reg.op_mode_select == MODE_SHUTDOWN || $past(wr_cfg) || $past(gc_reset)))
        else $error("one-shot did not return to shutdown");

    comp_set_a: assert property (@(posedge clk) disable iff (!nrst) // see R17
        (!int_mode && conv_done && (over_hit || under_hit) && !gc_reset) |=> active_reg)
        else $error("comparator alert not raised");

    comp_release_a: assert property (@(posedge clk) disable iff (!nrst) // see R18
        (!int_mode && conv_done && !over_hit && !under_hit && in_release && !gc_reset) |=> !active_reg)
        else $error("comparator alert not released");

    result_nibble_a: assert property (@(posedge clk) disable iff (!nrst) // see R12
        result_reg[RES_LSB-1:0] == LOW_NIBBLE_ZERO)
        else $error("result low nibble not zero");

    lower_write_a: assert property (@(posedge clk) disable iff (!nrst) // see R20
        (req.wr && req.ptr == PTR_LOWER && !gc_reset) |=> (lower_reg == ($past(req.wdata) & LIMIT_MASK)))
        else $error("lower limit write wrong");

    upper_write_a: assert property (@(posedge clk) disable iff (!nrst) // see R20
        (req.wr && req.ptr == PTR_UPPER && !gc_reset) |=> (upper_reg == ($past(req.wdata) & LIMIT_MASK)))
        else $error("upper limit write wrong");

    read_result_a: assert property (@(posedge clk) disable iff (!nrst) // see R26
        (req.rd && req.ptr == PTR_RESULT) |=> (rdata == $past(result_reg)))
        else $error("result read returned wrong word");

endmodule : tla_core

// >>> dv/tla_host.sv
// Controller model: issues whole-word register requests
`timescale 1ns/1ns
module tla_host import tla_pkg::*; (
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    output tla_req_t         req
);
    // Bus idle until a request is made
    initial req = '0;
    task automatic xfer(input logic w, input logic [1:0] p, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        req <= '{wr: w, rd: !w, ptr: p, wdata: d};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        q = rdata;
    endtask : xfer
endmodule : tla_host

// >>> dv/tla_core_tb.sv
// Self-checking bench of the temperature limit and alert core
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tla_core_tb import tla_pkg::*; ;
    logic        clk = 1'b0, nrst = 1'b0, ara_ok = 1'b0, gc_reset = 1'b0, conv_active, alert_out;
    logic [11:0] adc_value = 12'h000;
    logic [15:0] rdata, q;
    tla_req_t    req;
    int          error_cnt = 0, n_tests = 0, hy[4] = '{0, 16, 32, 64};
    // Short conversion and interval so each scenario costs a few hundred cycles
    always #5 clk = ~clk;
    tla_core #(.CONV_CYCLES(20), .RATE1_CYCLES(100)) i_tla_core (.clk(clk), .nrst(nrst), .req(req),
        .rdata(rdata), .ara_ok(ara_ok), .gc_reset(gc_reset), .adc_value(adc_value),
        .conv_active(conv_active), .alert_out(alert_out));
    tla_host i_tla_host (.clk(clk), .rdata(rdata), .req(req));
    ////////////////////////////////////////
    task automatic close_out;
        $display("TB: checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic rw(input logic w, input logic [1:0] p, input logic [15:0] d);
        i_tla_host.xfer(w, p, d, q);
        if (!w) `CHK(q, d)
    endtask : rw
    // New converter input, then a bounded wait for one conversion to end and land
    task automatic wc(input logic [11:0] v);
        logic s;
        s = 1'b0;
        @(posedge clk);
        adc_value <= v;
        for (int n = 0; n < 400 && !(s && conv_active === 1'b0); n++) begin
            @(negedge clk);
            s = s | (conv_active === 1'b1);
        end
        if (!s || conv_active !== 1'b0) error_cnt++;
        if (!s || conv_active !== 1'b0) close_out();
        repeat (2) @(posedge clk);
    endtask : wc
    // One-cycle strobe; the #1 keeps the following check clear of the update edge
    task automatic pulse(input logic a);
        @(posedge clk);
        {ara_ok, gc_reset} <= {a, !a};
        @(posedge clk);
        {ara_ok, gc_reset} <= 2'b00;
        #1;
    endtask : pulse
    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rw(1'b0, PTR_CONFIG, 16'h1022);
        rw(1'b0, PTR_UPPER, 16'h7FF8);
        wc(12'h191);
        rw(1'b0, PTR_RESULT, 16'h1910);
        rw(1'b1, PTR_UPPER, 16'h1908);
        rw(1'b0, PTR_UPPER, 16'h1900);
        wc(12'h191);
        `CHK(alert_out, 1'b0)
        rw(1'b0, PTR_CONFIG, 16'h1032);
        wc(12'h188);
        rw(1'b0, PTR_CONFIG, 16'h1022);
        rw(1'b1, PTR_LOWER, 16'h1000);
        rw(1'b1, PTR_CONFIG, 16'h103E);
        // Drop the alert left from comparator mode so the next event must raise it
        pulse(1'b1);
        `CHK(alert_out, 1'b1)
        wc(12'hFF0);
        `CHK(alert_out, 1'b0)
        pulse(1'b1);
        `CHK(alert_out, 1'b1)
        rw(1'b0, PTR_CONFIG, 16'h102E);
        rw(1'b0, PTR_CONFIG, 16'h1026);
        wc(12'hFF0);
        pulse(1'b0);
        `CHK(alert_out, 1'b1)
        rw(1'b1, PTR_UPPER, 16'h0000);
        // Every hysteresis code: one count short of release holds, the boundary releases
        for (int h = 0; h < 4; h++) begin
            rw(1'b1, PTR_CONFIG, 16'h8022 | 16'(h << 12));
            wc(12'h010);
            wc(12'(1 - hy[h]));
            `CHK(alert_out, 1'b1)
            wc(12'(0 - hy[h]));
            `CHK(alert_out, 1'b0)
        end
        rw(1'b1, PTR_CONFIG, 16'h1020);
        // Watch longer than one period, often enough to catch any conversion
        repeat (30) @(posedge clk);
        for (int n = 0; n < 12; n++) begin
            repeat (10) @(negedge clk);
            `CHK(conv_active, 1'b0)
        end
        rw(1'b1, PTR_CONFIG, 16'h1021);
        rw(1'b0, PTR_CONFIG, 16'h1021);
        wc(12'hFE0);
        rw(1'b0, PTR_CONFIG, 16'h1020);
        close_out();
    end
endmodule : tla_core_tb
